// >>> shared/cssel_map.svh
// Purpose: offsets, field positions, reset values and counts for the
//          clock source and start-up select block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef CSSEL_MAP_SVH
`define CSSEL_MAP_SVH

`define CSSEL_OFF_TRIM        12'h000
`define CSSEL_OFF_CFG         12'h004
`define CSSEL_OFF_STATUS      12'h008
`define CSSEL_OFF_CTRL        12'h00C

`define CSSEL_CLOCK_SOURCE_SELECT_FIELD_DEFAULT   4'h1
`define CSSEL_SUT_DEFAULT     2'h2

`define CSSEL_CLOCK_SOURCE_SELECT_FIELD_EXT_CLK   4'h0
`define CSSEL_CLOCK_SOURCE_SELECT_FIELD_IRC_LO    4'h1
`define CSSEL_CLOCK_SOURCE_SELECT_FIELD_IRC_HI    4'h4
`define CSSEL_CLOCK_SOURCE_SELECT_FIELD_ERC_LO    4'h5
`define CSSEL_CLOCK_SOURCE_SELECT_FIELD_ERC_HI    4'h8

`define CSSEL_CK_SHORT        5'h06
`define CSSEL_CK_LONG         5'h12

`define CSSEL_DLY_SHORT_MS_X10 41
`define CSSEL_DLY_LONG_MS     65
`define CSSEL_WDT_SHORT       17'h01000
`define CSSEL_WDT_LONG        17'h10000

`define CSSEL_CTRL_WAKE_BIT   0
`define CSSEL_CTRL_SLEEP_BIT  1

`endif

// >>> shared/cssel_pkg.sv
// Purpose: types for the clock source and start-up select block
// Assumes: nothing beyond the map header
// Notes:   source and sequencer state enumerations
package cssel_pkg;

  typedef enum logic [1:0] {
    CSSEL_SRC_EXT_CLK,
    CSSEL_SRC_INT_RC,
    CSSEL_SRC_EXT_RC,
    CSSEL_SRC_OTHER
  } cssel_src_t;

  typedef enum logic [2:0] {
    CSSEL_ST_RESET_DLY,
    CSSEL_ST_OSC_CK,
    CSSEL_ST_RUN,
    CSSEL_ST_SLEEP,
    CSSEL_ST_HALT
  } cssel_state_t;

endpackage

// >>> verification/cssel_osc_model.sv
// Purpose: selected and watchdog oscillator tick source
// Assumes: slow only changes while the block is held in reset
// Notes:   watchdog ticks every pclk cycle
module cssel_osc_model (
  input  wire logic pclk,
  input  wire logic slow,
  output logic      osc_tick,
  output logic      wdt_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_r;
  initial begin
    div_r    = 2'h0;
    osc_tick = 1'b0;
    wdt_tick = 1'b0;
  end
  always @(posedge pclk) begin
    div_r    <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
    osc_tick <= !slow || div_r == 2'h2;
    wdt_tick <= 1'b1;
  end
endmodule

// >>> verification/cssel_top_checker.sv
// Purpose: port assertions for cssel_top
// Assumes: fuse and factory inputs change only in reset
// Notes:   bound to every cssel_top
module cssel_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input logic            pready,
  input wire logic [3:0] clock_source_select_field,
  input wire logic [1:0] startup_time_field,
  input wire logic [7:0] factory_trim,
  input wire logic       osc_tick,
  input wire logic       wdt_tick,
  input logic [7:0]      trim_value,
  input logic [1:0]      osc_source,
  input logic [1:0]      freq_band,
  input logic            core_clk_en,
  input logic            xtal_select,
  input logic [3:0]      xtal_code
);
  logic [3:0]  cs;
  logic [1:0]  su;
  logic [16:0] osc_n, wdt_n, ck_need, dly_need;
  logic        up_r, boot_r;
  assign cs = clock_source_select_field;
  assign su = startup_time_field;
  assign ck_need  = (osc_source == 2'h2 && su != 2'h3) ? 17'h12 : 17'h6;
  assign dly_need = su == 2'h0 ? 17'h0 : su == 2'h2 ? 17'h10000 : 17'h1000;
  // counts since the core clock was last gated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_n  <= 17'h0;
      wdt_n  <= 17'h0;
      up_r   <= 1'b0;
      boot_r <= 1'b0;
    end else begin
      osc_n  <= core_clk_en ? 17'h0 : osc_n + {16'h0, osc_tick};
      wdt_n  <= core_clk_en ? 17'h0 : wdt_n + {16'h0, wdt_tick};
      up_r   <= 1'b1;
      boot_r <= boot_r | core_clk_en;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  chk_apb_answer: assert property (s_setup |=> s_answer)
    else $error("no one-cycle answer after setup");
  chk_erc_band: assert property (osc_source == 2'h2 |->
    cs inside {[4'h5:4'h8]} && freq_band == cs[1:0] - 2'h1)
    else $error("external RC decode wrong");
  chk_irc_band: assert property (osc_source == 2'h1 |->
    cs inside {[4'h1:4'h4]} && freq_band == cs[1:0] - 2'h1)
    else $error("internal RC decode wrong");
  chk_xtal_pass: assert property (xtal_select |->
    xtal_code == cs && osc_source == 2'h3 && !core_clk_en)
    else $error("crystal hand-off wrong");
  chk_halt_rsvd: assert property (
    su == 2'h3 && osc_source != 2'h2 |-> !core_clk_en)
    else $error("clock released on reserved start-up code");
  chk_osc_count: assert property (
    $rose(core_clk_en) |-> osc_n >= ck_need)
    else $error("too few oscillator cycles before release");
  chk_rst_delay: assert property (
    $rose(core_clk_en) && !boot_r |-> wdt_n >= dly_need)
    else $error("reset delay too short");
  chk_trim_load: assert property (
    !up_r |=> trim_value == $past(factory_trim))
    else $error("trim not loaded at reset");
endmodule

bind cssel_top cssel_checker u_chk (.*);

// >>> verification/cssel_top_tb.sv
// Purpose: self-checking bench for cssel_top
// Assumes: fuse pairs applied under reset, one run each
// Notes:   read expectations queued, matched on pready
`include "cssel_map.svh"
module cssel_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  clock_source_select_field, xtal_code;
  logic [1:0]  startup_time_field, osc_source, freq_band;
  logic [7:0]  factory_trim, trim_value;
  logic        osc_tick, wdt_tick, core_clk_en, xtal_select, slow;
  logic [32:0] exp_q[$];
  int          n_mismatch, n_tests;
  // {start-up, source}; first entry is the shipped default
  logic [5:0]  cases[11] = '{6'h21, 6'h05, 6'h38, 6'h13, 6'h16, 6'h00,
                              6'h30, 6'h09, 6'h32, 6'h04, 6'h07};
  cssel_top u_dut (.*);
  cssel_osc_model u_osc (.pclk(pclk), .slow(slow), .osc_tick(osc_tick),
                         .wdt_tick(wdt_tick));
  always #2 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (!wr) exp_q.push_back(e);
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_en(input logic v, input int lim);
    int n;
    n = 0;
    while (core_clk_en !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic run_case(input logic [5:0] f);
    logic [3:0] c;
    logic [1:0] src;
    logic       run;
    c   = f[3:0];
    src = c == 4'h0 ? 2'h0 : c < 4'h5 ? 2'h1 : c < 4'h9 ? 2'h2 : 2'h3;
    run = src != 2'h3 && !(f[5:4] == 2'h3 && src != 2'h2);
    presetn                   <= 1'b0;
    clock_source_select_field <= c;
    startup_time_field        <= f[5:4];
    factory_trim              <= 8'($urandom);
    slow                      <= 1'($urandom);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    if (run) wait_en(1'b1, 70000);
    else repeat (300) @(posedge pclk);
    check(core_clk_en, run);
    check(osc_source, src);
    check(xtal_code, src == 2'h3 ? c : 4'h0);
    check(xtal_select, src == 2'h3);
    check(trim_value, factory_trim);
    if (src inside {2'h1, 2'h2})
      check(freq_band, 2'(c[1:0] - 2'h1));
    apb(0, `CSSEL_OFF_TRIM, 0, {25'h0, factory_trim});
    apb(0, `CSSEL_OFF_CFG, 0, {27'h0, f});
    if (run) begin
      apb(1, `CSSEL_OFF_TRIM, {24'h0, ~factory_trim}, 0);
      apb(0, `CSSEL_OFF_TRIM, 0, {25'h0, ~factory_trim});
      apb(0, 12'h010, 0, 33'h100000000);
      apb(1, `CSSEL_OFF_CTRL, 32'h2, 0);
      wait_en(0, 50);
      check(core_clk_en, 0);
      apb(1, `CSSEL_OFF_CTRL, 32'h1, 0);
      wait_en(1, 300);
      check(core_clk_en, 1);
    end
  endtask
  task automatic test_done;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
    if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
      check({pslverr, prdata}, exp_q.pop_front());
  initial begin
    #(4 * 95000);
    n_mismatch++;
    test_done();
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; clock_source_select_field = '0;
    startup_time_field = '0; factory_trim = '0; slow = 0;
    n_mismatch = 0;
    n_tests = 0;
    void'($urandom(95949));
    @(posedge pclk);
    foreach (cases[i]) run_case(cases[i]);
    test_done();
  end
endmodule

// >>> verilog/cssel_top.sv
// Purpose: clock source decode, start-up sequencing and oscillator trim
// Assumes: osc_tick and wdt_tick are one-cycle pulses synchronous to pclk
// Notes:   fuse fields and the factory byte are sampled after reset release
//          decode outputs hold their reset values until then
//          halt is final until the next reset
//          sleep is honoured only in run, wake only in sleep
//          reset delays count watchdog ticks; their rate sets the time
//
// Summary of operation
// R1: codes 0101..1000 select external RC, four frequency bands.
// R2: external RC start-up: 18, 18+4.1ms, 18+65ms, 6+4.1ms by code.
// R3: codes 0001..0100 select internal RC at 1, 2, 4, 8 MHz.
// R4: shipped default is source code 0001 and start-up code 10.
// R5: internal RC start-up: 6, 6+4.1ms, 6+65ms; code 11 reserved.
// R6: factory calibration byte loads into trim register at every reset.
// R7: watchdog and reset delay are timed from the watchdog oscillator.
// R8: trim register is 8-bit read/write; higher value, higher frequency.
// R9: software keeps trim within 10% above nominal while writing memories.
// R10: code 0000 selects external clock on the clock input pin.
// R11: external clock start-up: 6, 6+4.1ms, 6+65ms; code 11 reserved.
// R12: external clock varies at most 2% per cycle outside reset.
// R13: reset delays are 4096 and 65536 watchdog oscillator cycles.
// R14: wake from deep sleep applies the same selected start-up period; here only the oscillator count reruns, without the reset delay.
// R15: count selected oscillator cycles, gate core clock until done.
// R16: other source codes are handed to the crystal oscillator block.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`include "cssel_map.svh"

module cssel_top
  import cssel_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  clock_source_select_field,
  input  wire logic [1:0]  startup_time_field,
  input  wire logic [7:0]  factory_trim,
  input  wire logic        osc_tick,
  input  wire logic        wdt_tick,
  output logic [7:0]       trim_value,
  output logic [1:0]       osc_source,
  output logic [1:0]       freq_band,
  output logic             core_clk_en,
  output logic             xtal_select,
  output logic [3:0]       xtal_code
);

  ////////////////////////////////////////////////////////////////////////
  // decode of the source code
  // codes from 1001 up belong to the crystal oscillator block
  function automatic cssel_src_t cssel_decode(input logic [3:0] code);
    if (code == `CSSEL_CLOCK_SOURCE_SELECT_FIELD_EXT_CLK)
      return CSSEL_SRC_EXT_CLK;
    else if (code >= `CSSEL_CLOCK_SOURCE_SELECT_FIELD_IRC_LO && code <= `CSSEL_CLOCK_SOURCE_SELECT_FIELD_IRC_HI)
      return CSSEL_SRC_INT_RC;
    else if (code >= `CSSEL_CLOCK_SOURCE_SELECT_FIELD_ERC_LO && code <= `CSSEL_CLOCK_SOURCE_SELECT_FIELD_ERC_HI)
      return CSSEL_SRC_EXT_RC;
    else
      return CSSEL_SRC_OTHER;
  endfunction

  logic [3:0]   clock_source_select_field_r;
  logic [1:0]   sut_r;
  logic         fuse_loaded_r;
  logic [7:0]   trim_r;
  logic [7:0]   trim_nxt;
  cssel_state_t state_r;
  cssel_state_t state_nxt;
  logic [16:0]  wdt_cnt_r;
  logic [16:0]  wdt_cnt_nxt;
  logic [4:0]   ck_cnt_r;
  logic [4:0]   ck_cnt_nxt;
  logic [31:0]  prdata_r;
  logic         pready_r;
  logic         pslverr_r;
  logic         clk_en_r;
  logic [1:0]   src_out_r;
  logic [1:0]   band_r;
  logic         xsel_r;
  logic [3:0]   xcode_r;

  ////////////////////////////////////////////////////////////////////////
  // start-up table lookup
  wire cssel_src_t src_w     = cssel_decode(clock_source_select_field_r);
  wire logic       is_erc    = src_w == CSSEL_SRC_EXT_RC;
  wire logic       other_w   = src_w == CSSEL_SRC_OTHER;
  // start-up code decode
  wire logic       sut_none  = sut_r == 2'h0;
  wire logic       sut_short = sut_r == 2'h1;
  wire logic       sut_long  = sut_r == 2'h2;
  wire logic       sut_alt   = sut_r == 2'h3;
  // code 11 only has a meaning for the external RC source
  wire logic       sut_rsvd  = !is_erc && sut_alt;
  // R2 ext rc count
  wire logic [4:0] erc_ck    = sut_alt ? `CSSEL_CK_SHORT : `CSSEL_CK_LONG;
  // R5 R11 six cycles
  wire logic [4:0] ck_need   = is_erc ? erc_ck : `CSSEL_CK_SHORT;
  // R13 delay lengths
  wire logic [16:0] dly_need =
      sut_none              ? 17'h00000 :
      sut_long              ? `CSSEL_WDT_LONG :
      (is_erc || sut_short) ? `CSSEL_WDT_SHORT :
                              17'h00000;
  // R1 R3 band select
  // band is the code's offset within its source
  wire logic [1:0] band_w   =
      (src_w == CSSEL_SRC_EXT_RC) ? 2'(clock_source_select_field_r - `CSSEL_CLOCK_SOURCE_SELECT_FIELD_ERC_LO) :
      (src_w == CSSEL_SRC_INT_RC) ? 2'(clock_source_select_field_r - `CSSEL_CLOCK_SOURCE_SELECT_FIELD_IRC_LO) :
                                    2'h0;

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  wire logic       acc     = psel && penable;
  wire logic       hit_tr  = paddr == `CSSEL_OFF_TRIM;
  wire logic       hit_cfg = paddr == `CSSEL_OFF_CFG;
  wire logic       hit_st  = paddr == `CSSEL_OFF_STATUS;
  wire logic       hit_ct  = paddr == `CSSEL_OFF_CTRL;
  wire logic       mapped  = hit_tr || hit_cfg || hit_st || hit_ct;
  wire logic       wr_tr   = acc && pwrite && hit_tr;
  wire logic       wr_ct   = acc && pwrite && hit_ct;
  wire logic       req_slp = wr_ct && pwdata[`CSSEL_CTRL_SLEEP_BIT];
  wire logic       req_wak = wr_ct && pwdata[`CSSEL_CTRL_WAKE_BIT];
  wire logic [31:0] trim_word = {24'h000000, trim_r};
  wire logic [31:0] cfg_word  = {26'h0000000, sut_r, clock_source_select_field_r};
  // status: reserved start-up code, source, sequencer state, clock gate
  wire logic [31:0] stat_word = {25'h0000000, sut_rsvd, src_w, state_r,
                                 clk_en_r};
  wire logic [31:0] rd_mux =
      hit_tr  ? trim_word :
      hit_cfg ? cfg_word :
      hit_st  ? stat_word :
                32'h00000000;

  // unmapped address answers with an error and zero data
  wire logic        setup_w  = psel && !penable;
  wire logic        perr_nxt = setup_w && !mapped;
  wire logic [31:0] prd_nxt  = (setup_w && !pwrite) ? rd_mux
                                                    : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////
  // counter steps
  // the compares close each phase, so the sums never wrap
  // R13 reset delay reached
  wire logic        wdt_done = wdt_cnt_r >= dly_need;
  // R15 oscillator count reached
  wire logic        ck_done  = ck_cnt_r >= ck_need;
  wire logic [16:0] wdt_inc  = 17'(wdt_cnt_r + 17'h00001);
  wire logic [4:0]  ck_inc   = 5'(ck_cnt_r + 5'h01);

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_nxt   = state_r;
    wdt_cnt_nxt = wdt_cnt_r;
    ck_cnt_nxt  = ck_cnt_r;
    case (state_r)
      CSSEL_ST_RESET_DLY: begin
        // R7 watchdog timed
        // the delay length is only known once the fields are latched
        if (!fuse_loaded_r) begin
          wdt_cnt_nxt = 17'h00000;
        end else if (wdt_done) begin
          state_nxt  = CSSEL_ST_OSC_CK;
          ck_cnt_nxt = 5'h00;
        end else if (wdt_tick) begin
          wdt_cnt_nxt = wdt_inc;
        end
      end
      CSSEL_ST_OSC_CK: begin
        // R15 count oscillator
        // an unknown source or a reserved code never releases the core
        if (other_w || sut_rsvd) begin
          state_nxt = CSSEL_ST_HALT;
        end else if (ck_done) begin
          state_nxt = CSSEL_ST_RUN;
        end else if (osc_tick) begin
          ck_cnt_nxt = ck_inc;
        end
      end
      CSSEL_ST_RUN: begin
        // a wake request here has no effect
        if (req_slp) begin
          state_nxt = CSSEL_ST_SLEEP;
        end
      end
      CSSEL_ST_SLEEP: begin
        // R14 wake start-up
        // only the oscillator count reruns, not the reset delay
        if (req_wak) begin
          state_nxt  = CSSEL_ST_OSC_CK;
          ck_cnt_nxt = 5'h00;
        end
      end
      CSSEL_ST_HALT: begin
        // left only through reset
        state_nxt = CSSEL_ST_HALT;
      end
      default: begin
        state_nxt = CSSEL_ST_RESET_DLY;
      end
    endcase
  end

  // R8 trim write
  // a write in the load edge is lost: the factory byte wins
  assign trim_nxt = wr_tr ? pwdata[7:0] : trim_r;

  ////////////////////////////////////////////////////////////////////////
  // output next values
  // decode outputs keep their reset value until the fields are latched,
  // so the far side never sees the shipped default decoded for a cycle
  logic       clk_en_nxt;
  logic [1:0] src_out_nxt;
  logic [1:0] band_nxt;
  logic       xsel_nxt;
  logic [3:0] xcode_nxt;

  // R15 gate core clock
  assign clk_en_nxt  = state_nxt == CSSEL_ST_RUN;
  // R10 external clock
  assign src_out_nxt = fuse_loaded_r ? src_w : 2'h0;
  assign band_nxt    = fuse_loaded_r ? band_w : 2'h0;
  // R16 hand to crystal
  assign xsel_nxt    = fuse_loaded_r && other_w;
  assign xcode_nxt   = xsel_nxt ? clock_source_select_field_r : 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // R4 shipped defaults
      clock_source_select_field_r       <= `CSSEL_CLOCK_SOURCE_SELECT_FIELD_DEFAULT;
      sut_r         <= `CSSEL_SUT_DEFAULT;
      fuse_loaded_r <= 1'b0;
      trim_r        <= 8'h00;
    end else if (!fuse_loaded_r) begin
      // R6 factory trim load
      // fields are taken once; later pin changes wait for a reset
      clock_source_select_field_r       <= clock_source_select_field;
      sut_r         <= startup_time_field;
      fuse_loaded_r <= 1'b1;
      trim_r        <= factory_trim;
    end else begin
      trim_r        <= trim_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= CSSEL_ST_RESET_DLY;
      wdt_cnt_r <= 17'h00000;
      ck_cnt_r  <= 5'h00;
    end else begin
      state_r   <= state_nxt;
      wdt_cnt_r <= wdt_cnt_nxt;
      ck_cnt_r  <= ck_cnt_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en_r  <= 1'b0;
      src_out_r <= 2'h0;
      band_r    <= 2'h0;
      xsel_r    <= 1'b0;
      xcode_r   <= 4'h0;
    end else begin
      clk_en_r  <= clk_en_nxt;
      src_out_r <= src_out_nxt;
      band_r    <= band_nxt;
      xsel_r    <= xsel_nxt;
      xcode_r   <= xcode_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb response: no wait state, answer registered at the setup cycle's closing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup_w;
      pslverr_r <= perr_nxt;
      prdata_r  <= prd_nxt;
    end
  end

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign trim_value  = trim_r;
  assign osc_source  = src_out_r;
  assign freq_band   = band_r;
  assign core_clk_en = clk_en_r;
  assign xtal_select = xsel_r;
  assign xtal_code   = xcode_r;

endmodule
